/* File: pdt_defines.svh */
// register indices, field positions, reset values and timing counts
// assumes a 100 MHz system clock; byte address on the bus is four times an index
`ifndef PDT_DEFINES_SVH
`define PDT_DEFINES_SVH

// ----------------------------------------------------------------------
// register indices
// ----------------------------------------------------------------------
`define PDT_IX_PRIO 16'hFF21
`define PDT_IX_EN_A 16'hFF23
`define PDT_IX_FLAG_A 16'hFF25
`define PDT_IX_EN_B 16'hFF26
`define PDT_IX_FLAG_B 16'hFF27
`define PDT_IX_PAIR_A 16'hFF30
`define PDT_IX_CTL0 16'hFF31
`define PDT_IX_CTL1 16'hFF32
`define PDT_IX_RLD0 16'hFF33
`define PDT_IX_RLD1 16'hFF34
`define PDT_IX_CNT0 16'hFF35
`define PDT_IX_CNT1 16'hFF36
`define PDT_IX_PAIR_B 16'hFF38
`define PDT_IX_CTL2 16'hFF39
`define PDT_IX_CTL3 16'hFF3A
`define PDT_IX_RLD2 16'hFF3B
`define PDT_IX_RLD3 16'hFF3C
`define PDT_IX_CNT2 16'hFF3D
`define PDT_IX_CNT3 16'hFF3E

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define PDT_BIT_PRESET 1
`define PDT_BIT_RUN 0
`define PDT_BIT_IRQ_LO 6
`define PDT_BIT_IRQ_HI 7

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define PDT_RLD_RST 8'hFF
`define PDT_CNT_RST 8'hFF

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define PDT_CLK_MHZ 100
`define PDT_LATCH_TMO_US 730
`define PDT_LATCH_TMO_CYC (`PDT_LATCH_TMO_US * `PDT_CLK_MHZ)

`endif

/* File: pdt_pkg.sv */
// types shared by the quad down-timer
// assumes pdt_defines.svh for all numeric constants
package pdt_pkg;

  // ----------------------------------------------------------------------
  // register layouts
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic evcnt;
    logic fcsel;
    logic plpol;
    logic [1:0] psc;
    logic cont;
    logic pset;
    logic prun;
  } pdt_tctl_t;

  typedef struct packed {
    logic pw;
    logic output_channel_sel;
    logic output_clock_enable;
    logic [1:0] cksel;
  } pdt_pcfg_t;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ACK = 1'b1
  } pdt_bus_e;

  // ----------------------------------------------------------------------
  // whole state of the block
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [3:0] sy1;
    logic [3:0] sy2;
    logic [3:0] sy3;
    logic [3:0] fv;
    logic [3:0][5:0] pre;
    logic [3:0][7:0] cnt;
    logic [3:0][7:0] rld;
    pdt_tctl_t [3:0] ctl;
    logic [3:0] run_act;
    pdt_pcfg_t [1:0] pcfg;
    logic [1:0][1:0] prio;
    logic [3:0] en;
    logic [3:0] flag;
    logic [1:0] lat_v;
    logic [1:0][7:0] lat_val;
    logic [1:0][16:0] tmo;
    logic timer_output_clock;
    logic o_true;
    logic o_inv;
    logic [1:0] irq;
    pdt_bus_e bus;
    logic [7:0] rdat;
  } pdt_state_t;

endpackage : pdt_pkg

/* File: pdt_timer_quad.sv */
// four 8-bit down-counters, pairable to 16 bits, behind a wishbone slave
// assumes oscillators and event inputs are asynchronous pins; cpu mask is synchronous
//
// Design decision made here: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "pdt_defines.svh"

module pdt_timer_quad #(
  parameter int unsigned LATCH_TMO_CYC = `PDT_LATCH_TMO_CYC
) (
  // clock and reset
  input wire logic I_SYS_CLK,
  input wire logic I_RST,
  // wishbone slave
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [17:2] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  output logic [31:0] O_WB_DAT,
  output logic O_WB_ACK,
  // clock and event pins
  input wire logic I_SLOW_OSC,
  input wire logic I_FAST_OSC,
  input wire logic I_EVENT_INPUT_A,
  input wire logic I_EVENT_INPUT_B,
  // cpu interrupt side
  input wire logic [1:0] I_CPU_IRQ_MASK_FLAGS,
  output logic [1:0] O_IRQ_REQ,
  // timer output clock pins
  output logic O_OUT_PIN_TRUE,
  output logic O_OUT_PIN_INVERTED
);
  import pdt_pkg::*;

  // ----------------------------------------------------------------------
  // constants
  // ----------------------------------------------------------------------
  localparam logic [15:0] CTL_IX [4] = '{`PDT_IX_CTL0, `PDT_IX_CTL1, `PDT_IX_CTL2, `PDT_IX_CTL3};
  localparam logic [15:0] RLD_IX [4] = '{`PDT_IX_RLD0, `PDT_IX_RLD1, `PDT_IX_RLD2, `PDT_IX_RLD3};
  localparam logic [15:0] CNT_IX [4] = '{`PDT_IX_CNT0, `PDT_IX_CNT1, `PDT_IX_CNT2, `PDT_IX_CNT3};
  localparam logic [16:0] TMO_LOAD = 17'(LATCH_TMO_CYC);
  localparam pdt_state_t RST_ST = '{
    rld: {4{`PDT_RLD_RST}},
    cnt: {4{`PDT_CNT_RST}},
    o_true: 1'b1,
    bus: BUS_IDLE,
    default: '0
  };

  // ----------------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------------
  function automatic logic [5:0] psc_mask(input logic [1:0] sel);
    case (sel)
      2'b11: psc_mask = 6'h3F;
      2'b10: psc_mask = 6'h0F;
      2'b01: psc_mask = 6'h03;
      default: psc_mask = 6'h00;
    endcase
  endfunction : psc_mask

  function automatic logic is_high(input int i);
    is_high = (i % 2 == 1);
  endfunction : is_high

  function automatic logic has_event_pin(input int i);
    has_event_pin = (i % 2 == 0);
  endfunction : has_event_pin

  function automatic logic low_paired(input int i, input pdt_pcfg_t [1:0] c);
    low_paired = (i % 2 == 0) && c[i / 2].pw;
  endfunction : low_paired

  function automatic logic high_paired(input int i, input pdt_pcfg_t [1:0] c);
    high_paired = (i % 2 == 1) && c[i / 2].pw;
  endfunction : high_paired

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  pdt_state_t s;
  pdt_state_t n;
  logic [3:0] fall;
  logic [3:0] rise;
  logic [3:0] tk;
  logic [3:0] gate;
  logic [3:0] evm;
  logic [3:0] uf;
  logic [3:0] reload_ev;
  logic [3:0] clr;
  logic req;
  logic wr;
  logic [15:0] idx;
  logic [7:0] wd;
  logic tsrc;
  logic edge_hit;

  always_comb begin
    n = s;
    fall = '0;
    rise = '0;
    tk = '0;
    gate = '1;
    evm = '0;
    uf = '0;
    reload_ev = '0;
    clr = '0;
    tsrc = 1'b0;
    edge_hit = 1'b0;
    req = I_WB_CYC && I_WB_STB && (s.bus == BUS_IDLE);
    wr = req && I_WB_WE && I_WB_SEL[0];
    idx = I_WB_ADR;
    wd = I_WB_DAT[7:0];

    // ----------------------------------------------------------------------
    // pin synchronisers, change taken once stages two and three agree
    // ----------------------------------------------------------------------
    n.sy1 = {I_EVENT_INPUT_B, I_EVENT_INPUT_A, I_FAST_OSC, I_SLOW_OSC};
    n.sy2 = s.sy1;
    n.sy3 = s.sy2;
    for (int k = 0; k < 4; k++) begin
      if (s.sy2[k] == s.sy3[k]) begin
        n.fv[k] = s.sy2[k];
      end
    end
    fall = s.fv & ~n.fv;
    rise = ~s.fv & n.fv;

    // ----------------------------------------------------------------------
    // input clock selection per timer
    // ----------------------------------------------------------------------
    for (int i = 0; i < 4; i++) begin
      tsrc = s.pcfg[i/2].cksel[i%2] ? fall[1] : fall[0];
      if (tsrc) begin
        n.pre[i] = s.pre[i] + 6'h01;
      end
      evm[i] = has_event_pin(i) && s.ctl[i].evcnt;
      edge_hit = s.ctl[i].plpol ? rise[2 + i/2] : fall[2 + i/2];
      if (evm[i]) begin
        tk[i] = edge_hit;
      end else begin
        tk[i] = tsrc && ((s.pre[i] & psc_mask(s.ctl[i].psc)) == psc_mask(s.ctl[i].psc));
      end
      if (has_event_pin(i) && s.ctl[i].fcsel && !s.ctl[i].evcnt) begin
        gate[i] = (s.fv[2 + i/2] == s.ctl[i].plpol);
      end
    end

    // ----------------------------------------------------------------------
    // counters
    // ----------------------------------------------------------------------
    for (int i = 0; i < 4; i++) begin
      if (high_paired(i, s.pcfg)) begin
        n.run_act[i] = 1'b0;
        n.ctl[i].prun = 1'b0;
      end else begin
        if (evm[i]) begin
          n.run_act[i] = s.ctl[i].prun;
        end
        if (tk[i]) begin
          if (s.run_act[i] && gate[i]) begin
            if (s.cnt[i] == 8'h00) begin
              if (low_paired(i, s.pcfg)) begin
                if (s.cnt[i|1] == 8'h00) begin
                  n.cnt[i] = s.rld[i];
                  n.cnt[i|1] = s.rld[i|1];
                  uf[i|1] = 1'b1;
                  reload_ev[i] = 1'b1;
                end else begin
                  n.cnt[i] = 8'hFF;
                  n.cnt[i|1] = s.cnt[i|1] - 8'h01;
                end
              end else begin
                n.cnt[i] = s.rld[i];
                uf[i] = 1'b1;
                reload_ev[i] = 1'b1;
              end
            end else begin
              n.cnt[i] = s.cnt[i] - 8'h01;
            end
          end
          if (!evm[i]) begin
            n.run_act[i] = s.ctl[i].prun;
          end
        end
        if (reload_ev[i] && !s.ctl[i].cont) begin
          n.ctl[i].prun = 1'b0;
          n.run_act[i] = 1'b0;
        end
      end
    end

    // ----------------------------------------------------------------------
    // timer output clock
    // ----------------------------------------------------------------------
    if (s.pcfg[0].pw || s.pcfg[0].output_channel_sel) begin
      tsrc = uf[1];
    end else begin
      tsrc = uf[0];
    end
    if (tsrc) begin
      n.timer_output_clock = ~s.timer_output_clock;
    end
    n.o_true = s.pcfg[0].output_clock_enable ? n.timer_output_clock : 1'b1;
    n.o_inv = s.pcfg[0].output_clock_enable ? ~n.timer_output_clock : 1'b0;

    // ----------------------------------------------------------------------
    // interrupt requests
    // ----------------------------------------------------------------------
    for (int p = 0; p < 2; p++) begin
      n.irq[p] = ((s.flag[2*p+1] && s.en[2*p+1]) ||
                  (s.flag[2*p] && s.en[2*p] && !s.pcfg[p].pw)) &&
                 (s.prio[p] > I_CPU_IRQ_MASK_FLAGS);
    end

    // ----------------------------------------------------------------------
    // capture timeout
    // ----------------------------------------------------------------------
    for (int p = 0; p < 2; p++) begin
      if (s.tmo[p] != 17'h00000) begin
        n.tmo[p] = s.tmo[p] - 17'h00001;
        if (s.tmo[p] == 17'h00001) begin
          n.lat_v[p] = 1'b0;
        end
      end
    end

    // ----------------------------------------------------------------------
    // bus access
    // ----------------------------------------------------------------------
    n.bus = req ? BUS_ACK : BUS_IDLE;
    if (req) begin
      n.rdat = 8'h00;
      case (idx)
        `PDT_IX_PRIO: begin
          n.rdat = {2'b00, s.prio[1], s.prio[0], 2'b00};
          if (wr) begin
            n.prio[1] = wd[5:4];
            n.prio[0] = wd[3:2];
          end
        end
        `PDT_IX_EN_A: begin
          n.rdat = {s.en[1], s.en[0], 6'h00};
          if (wr) begin
            n.en[1:0] = wd[`PDT_BIT_IRQ_HI:`PDT_BIT_IRQ_LO];
          end
        end
        `PDT_IX_EN_B: begin
          n.rdat = {s.en[3], s.en[2], 6'h00};
          if (wr) begin
            n.en[3:2] = wd[`PDT_BIT_IRQ_HI:`PDT_BIT_IRQ_LO];
          end
        end
        `PDT_IX_FLAG_A: begin
          n.rdat = {s.flag[1], s.flag[0], 6'h00};
          if (wr) begin
            clr[1:0] = wd[`PDT_BIT_IRQ_HI:`PDT_BIT_IRQ_LO];
          end
        end
        `PDT_IX_FLAG_B: begin
          n.rdat = {s.flag[3], s.flag[2], 6'h00};
          if (wr) begin
            clr[3:2] = wd[`PDT_BIT_IRQ_HI:`PDT_BIT_IRQ_LO];
          end
        end
        `PDT_IX_PAIR_A: begin
          n.rdat = {3'b000, s.pcfg[0]};
          if (wr) begin
            n.pcfg[0] = pdt_pcfg_t'(wd[4:0]);
          end
        end
        `PDT_IX_PAIR_B: begin
          n.rdat = {3'b000, s.pcfg[1]};
          if (wr) begin
            n.pcfg[1] = pdt_pcfg_t'(wd[4:0]);
          end
        end
        default: begin
          n.rdat = 8'h00;
        end
      endcase
      for (int i = 0; i < 4; i++) begin
        if (idx == CTL_IX[i]) begin
          n.rdat = {s.ctl[i][7:2], 1'b0, s.ctl[i].prun | s.run_act[i]};
          if (wr) begin
            n.ctl[i] = pdt_tctl_t'({wd[7:2], 1'b0, n.ctl[i].prun});
            if (!high_paired(i, s.pcfg)) begin
              n.ctl[i].prun = wd[`PDT_BIT_RUN];
              if (wd[`PDT_BIT_PRESET]) begin
                n.cnt[i] = s.rld[i];
                if (low_paired(i, s.pcfg)) begin
                  n.cnt[i|1] = s.rld[i|1];
                end
              end
            end
          end
        end
        if (idx == RLD_IX[i]) begin
          n.rdat = s.rld[i];
          if (wr) begin
            n.rld[i] = wd;
          end
        end
        if (idx == CNT_IX[i]) begin
          if (is_high(i) && s.lat_v[i/2]) begin
            n.rdat = s.lat_val[i/2];
          end else begin
            n.rdat = s.cnt[i];
          end
          if (is_high(i)) begin
            n.lat_v[i/2] = 1'b0;
            n.tmo[i/2] = 17'h00000;
          end else if (s.pcfg[i/2].pw) begin
            n.lat_v[i/2] = 1'b1;
            n.lat_val[i/2] = s.cnt[i|1];
            n.tmo[i/2] = TMO_LOAD;
          end
        end
      end
    end

    // ----------------------------------------------------------------------
    // flags, set wins over clear
    // ----------------------------------------------------------------------
    n.flag = (s.flag & ~clr) | uf;
  end

  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      s <= RST_ST;
    end else begin
      s <= n;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign O_WB_DAT = {24'h000000, s.rdat};
  assign O_WB_ACK = (s.bus == BUS_ACK);
  assign O_IRQ_REQ = s.irq;
  assign O_OUT_PIN_TRUE = s.o_true;
  assign O_OUT_PIN_INVERTED = s.o_inv;

endmodule : pdt_timer_quad
`default_nettype wire

/* File: pdt_timer_quad_sva.sv */
// bus, pin and request checks for the quad down-timer
// assumes binding to pdt_timer_quad; sees its ports only
`timescale 1ns/1ps
`default_nettype none

module pdt_timer_quad_sva (
  // clock and reset
  input wire logic I_SYS_CLK,
  input wire logic I_RST,
  // watched ports
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [17:2] I_WB_ADR,
  input wire logic [1:0] I_CPU_IRQ_MASK_FLAGS,
  input wire logic [31:0] O_WB_DAT,
  input wire logic O_WB_ACK,
  input wire logic [1:0] O_IRQ_REQ,
  input wire logic O_OUT_PIN_TRUE,
  input wire logic O_OUT_PIN_INVERTED
);
  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (I_RST);
  wire logic req = I_WB_CYC && I_WB_STB && !O_WB_ACK;

  a_ack_after_req: assert property (req |=> O_WB_ACK)
    else $error("no ack after request");
  a_ack_one_cycle: assert property (O_WB_ACK |=> !O_WB_ACK)
    else $error("ack longer than one cycle");
  a_ack_needs_req: assert property (!req |=> !O_WB_ACK)
    else $error("ack without request");
  a_dat_upper_zero: assert property (O_WB_ACK |-> O_WB_DAT[31:8] == 24'h000000)
    else $error("upper read data not zero");
  a_preset_reads_zero: assert property (O_WB_ACK && !$past(I_WB_WE) &&
    $past(I_WB_ADR) inside {16'hFF31, 16'hFF32, 16'hFF39, 16'hFF3A} |-> !O_WB_DAT[1])
    else $error("preset strobe read as one");
  a_pins_inverse: assert property (O_OUT_PIN_TRUE != O_OUT_PIN_INVERTED)
    else $error("output pins not inverse");
  a_pins_at_reset: assert property ($fell(I_RST) |-> O_OUT_PIN_TRUE && !O_OUT_PIN_INVERTED)
    else $error("output pins wrong after reset");
  a_irq_masked: assert property ((I_CPU_IRQ_MASK_FLAGS == 2'h3) [*2] |=> O_IRQ_REQ == 2'h0)
    else $error("request above top mask level");

  c_write: cover property (O_WB_ACK && $past(I_WB_WE));
  c_irq: cover property ($rose(O_IRQ_REQ[0]));
  c_toggle: cover property ($changed(O_OUT_PIN_TRUE));
endmodule : pdt_timer_quad_sva

bind pdt_timer_quad pdt_timer_quad_sva u_sva (.I_SYS_CLK, .I_RST, .I_WB_CYC, .I_WB_STB,
  .I_WB_WE, .I_WB_ADR, .I_CPU_IRQ_MASK_FLAGS, .O_WB_DAT, .O_WB_ACK, .O_IRQ_REQ,
  .O_OUT_PIN_TRUE, .O_OUT_PIN_INVERTED);
`default_nettype wire

/* File: pdt_pin_model.sv */
// oscillator and event pin model for the quad down-timer
// assumes a 100 MHz system clock; event pin idles high
`timescale 1ns/1ps
`default_nettype none

module pdt_pin_model (
  // clock, reset, pulse request
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_pulse,
  // pins
  output logic o_slow_osc,
  output logic o_fast_osc,
  output logic o_event
);
  logic [4:0] div;
  logic [2:0] low;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      div <= 5'h00;
      low <= 3'h0;
    end else begin
      div <= div + 5'h01;
      low <= i_pulse ? 3'h6 : (low != 3'h0 ? low - 3'h1 : 3'h0);
    end
  end
  // slow ticks every 32 cycles, fast every 8
  assign o_slow_osc = div[4];
  assign o_fast_osc = div[2];
  // one low pulse of six cycles per request
  assign o_event = (low == 3'h0);
endmodule : pdt_pin_model
`default_nettype wire

/* File: test_pdt_timer_quad.sv */
// self-checking bench for the quad down-timer
// assumes pdt_pin_model drives oscillators and both event pins
`timescale 1ns/1ps
`default_nettype none

module test_pdt_timer_quad;
  typedef struct packed {logic [15:0] a; logic w; logic [7:0] d; logic [7:0] e;} pdt_row_t;
  logic clk, rst, cyc, stb, we, pulse;
  logic [15:0] adr;
  logic [31:0] wdat, rdat;
  logic [1:0] mask;
  wire logic [31:0] dat;
  wire logic ack, pt, pi, slow, fast, evb;
  wire logic [1:0] irq;
  int n_mismatch = 0;
  int n_compared = 0;
  pdt_row_t rows [15] = '{
    '{16'hFF33, 1'b0, 8'h00, 8'hFF},
    '{16'hFF35, 1'b0, 8'h00, 8'hFF},
    '{16'hFF3E, 1'b0, 8'h00, 8'hFF},
    '{16'hFF35, 1'b1, 8'h00, 8'h00},
    '{16'hFF35, 1'b0, 8'h00, 8'hFF},
    '{16'hFF21, 1'b0, 8'h00, 8'h00},
    '{16'hFF21, 1'b1, 8'h3C, 8'h00},
    '{16'hFF21, 1'b0, 8'h00, 8'h3C},
    '{16'hFF23, 1'b0, 8'h00, 8'h00},
    '{16'hFF25, 1'b0, 8'h00, 8'h00},
    '{16'hFF33, 1'b1, 8'h05, 8'h00},
    '{16'hFF31, 1'b1, 8'h02, 8'h00},
    '{16'hFF31, 1'b0, 8'h00, 8'h00},
    '{16'hFF35, 1'b0, 8'h00, 8'h05},
    '{16'h0000, 1'b0, 8'h00, 8'h00}};

  pdt_timer_quad #(.LATCH_TMO_CYC(40)) dut (.I_SYS_CLK(clk), .I_RST(rst), .I_WB_CYC(cyc),
    .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(4'h1), .I_WB_DAT(wdat),
    .O_WB_DAT(dat), .O_WB_ACK(ack), .I_SLOW_OSC(slow), .I_FAST_OSC(fast),
    .I_EVENT_INPUT_A(evb), .I_EVENT_INPUT_B(evb), .I_CPU_IRQ_MASK_FLAGS(mask),
    .O_IRQ_REQ(irq), .O_OUT_PIN_TRUE(pt), .O_OUT_PIN_INVERTED(pi));
  pdt_pin_model u_pins (.i_clk(clk), .i_rst(rst), .i_pulse(pulse), .o_slow_osc(slow),
    .o_fast_osc(fast), .o_event(evb));

  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic bus(input logic [15:0] a, input logic w, input logic [7:0] d);
    int k;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    k = 0;
    @(posedge clk);
    while (ack !== 1'b1 && k < 50) begin
      @(posedge clk);
      k++;
    end
    if (k == 50) n_mismatch++;
    rdat = dat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    bus(a, 1'b0, 8'h00);
    chk(rdat, {24'h000000, e});
  endtask : rd
  task automatic ev;
    pulse <= 1'b1;
    @(posedge clk);
    pulse <= 1'b0;
    repeat (16) @(posedge clk);
  endtask : ev
  task automatic gap(output int n);
    logic p;
    p = pt;
    n = 1;
    @(posedge clk);
    while (pt === p && n < 999) begin
      @(posedge clk);
      n++;
    end
  endtask : gap
  task automatic end_of_test;
    $display("TB: compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  // ----------------------------------------------------------------------
  // stimulus
  // ----------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #400000;
    n_mismatch++;
    end_of_test();
  end
  initial begin
    int k;
    {rst, cyc, stb, we, pulse, adr, wdat, mask} = {1'b1, 54'h0};
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    foreach (rows[i]) begin
      if (rows[i].w) bus(rows[i].a, 1'b1, rows[i].d);
      else rd(rows[i].a, rows[i].e);
    end
    $display("TB: register table done");
    bus(16'hFF23, 1'b1, 8'h40);
    bus(16'hFF21, 1'b1, 8'h04);
    bus(16'hFF31, 1'b1, 8'h01);
    k = 0;
    while (irq[0] !== 1'b1 && k < 3000) begin
      @(posedge clk);
      k++;
    end
    chk(irq, 2'h1);
    rd(16'hFF31, 8'h00);
    rd(16'hFF25, 8'h40);
    mask <= 2'h3;
    repeat (3) @(posedge clk);
    chk(irq, 2'h0);
    mask <= 2'h0;
    repeat (100) @(posedge clk);
    chk(irq, 2'h1);
    rd(16'hFF35, 8'h05);
    bus(16'hFF25, 1'b1, 8'h40);
    rd(16'hFF25, 8'h00);
    chk(irq, 2'h0);
    $display("TB: one-shot done");
    bus(16'hFF34, 1'b1, 8'h02);
    bus(16'hFF30, 1'b1, 8'h0C);
    bus(16'hFF32, 1'b1, 8'h07);
    gap(k);
    gap(k);
    chk(k, 96);
    rd(16'hFF32, 8'h05);
    rd(16'hFF25, 8'h80);
    bus(16'hFF30, 1'b1, 8'h04);
    gap(k);
    chk(k, 999);
    chk(pi, !pt);
    bus(16'hFF32, 1'b1, 8'h04);
    repeat (100) @(posedge clk);
    rd(16'hFF32, 8'h04);
    $display("TB: continuous done");
    bus(16'hFF33, 1'b1, 8'h00);
    bus(16'hFF30, 1'b1, 8'h05);
    bus(16'hFF31, 1'b1, 8'h17);
    gap(k);
    gap(k);
    chk(k, 128);
    bus(16'hFF33, 1'b1, 8'h20);
    bus(16'hFF31, 1'b1, 8'h43);
    repeat (400) @(posedge clk);
    rd(16'hFF31, 8'h41);
    bus(16'hFF31, 1'b1, 8'h63);
    repeat (400) @(posedge clk);
    rd(16'hFF31, 8'h60);
    rd(16'hFF35, 8'h20);
    $display("TB: prescaler and gate done");
    bus(16'hFF3B, 1'b1, 8'h10);
    bus(16'hFF39, 1'b1, 8'h82);
    bus(16'hFF39, 1'b1, 8'h81);
    repeat (3) ev();
    rd(16'hFF3D, 8'h0D);
    bus(16'hFF39, 1'b1, 8'hA1);
    repeat (2) ev();
    rd(16'hFF3D, 8'h0B);
    $display("TB: event count done");
    bus(16'hFF3B, 1'b1, 8'h01);
    bus(16'hFF3C, 1'b1, 8'h05);
    bus(16'hFF38, 1'b1, 8'h10);
    bus(16'hFF39, 1'b1, 8'hA3);
    bus(16'hFF3A, 1'b1, 8'h01);
    rd(16'hFF3A, 8'h00);
    ev();
    rd(16'hFF3D, 8'h00);
    ev();
    rd(16'hFF3E, 8'h05);
    rd(16'hFF3E, 8'h04);
    $display("TB: pair latch done");
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(16'hFF3B, 8'hFF);
    rd(16'hFF3D, 8'hFF);
    $display("TB: second reset done");
    end_of_test();
  end
endmodule : test_pdt_timer_quad
`default_nettype wire
